// ===== hdl/pcp_codec_port.sv
// two-channel pcm / i2s codec serial port with an axi4-lite register slave
`timescale 1ns/100ps
module pcp_codec_port
	import pcp_pkg::*;
#(
	parameter int unsigned DATA_W = 32
) (
	input  wire logic        REF_CLK,
	input  wire logic        RESETN,
	input  wire logic [7:0]  AWADDR,
	input  wire logic [2:0]  AWPROT,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	input  wire logic [7:0]  ARADDR,
	input  wire logic [2:0]  ARPROT,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RVALID,
	input  wire logic        RREADY,
	input  wire logic        BCLK_IN,
	output logic             BCLK_OUT,
	output logic             BCLK_OE,
	input  wire logic        FSYNC_IN,
	output logic             FSYNC_OUT,
	output logic             FSYNC_OE,
	input  wire logic        DIN,
	output logic             DOUT,
	output logic             DOUT_OE
);
	// ==================================================================
	// companding helpers
	function automatic logic [7:0] enc_mu(input logic [15:0] s);
		logic [16:0] mag;
		logic [2:0]  ex;
		logic [16:0] sh;
		mag = s[15] ? (17'h0 - {s[15], s}) : {1'b0, s};
		if (mag > `PCP_MU_CLIP)
			mag = `PCP_MU_CLIP;
		mag = mag + `PCP_MU_BIAS;
		ex = 3'd0;
		for (int i = 0; i < 8; i++) begin
			if (mag[7 + i])
				ex = 3'(i);
		end
		sh = mag >> ({1'b0, ex} + 4'd3);  // four bits wide, so the top segment does not wrap
		return ~{s[15], ex, sh[3:0]};
	endfunction

	function automatic logic [15:0] dec_mu(input logic [7:0] c);
		logic [7:0]  u;
		logic [16:0] t;
		u = ~c;
		t = ({9'h0, u[3:0], 3'b000} + `PCP_MU_BIAS) << u[6:4];
		return u[7] ? 16'(`PCP_MU_BIAS - t) : 16'(t - `PCP_MU_BIAS);
	endfunction

	function automatic logic [7:0] enc_a(input logic [15:0] s);
		logic [16:0] mag;
		logic [2:0]  ex;
		logic [16:0] sh;
		mag = s[15] ? (17'h0 - {s[15], s}) : {1'b0, s};
		mag = mag >> 3;
		ex = 3'd0;
		for (int i = 1; i < 8; i++) begin
			if (mag[4 + i])
				ex = 3'(i);
		end
		sh = (ex == 3'd0) ? (mag >> 1) : (mag >> ex);
		return {~s[15], ex, sh[3:0]} ^ `PCP_A_XOR;
	endfunction

	function automatic logic [15:0] dec_a(input logic [7:0] c);
		logic [7:0]  u;
		logic [15:0] t;
		u = c ^ `PCP_A_XOR;
		t = {8'h0, u[3:0], 4'h8};
		if (u[6:4] != 3'd0)
			t = t + 16'h0100;
		if (u[6:4] > 3'd1)
			t = t << (u[6:4] - 3'd1);
		return u[7] ? t : (16'h0 - t);
	endfunction

	// ==================================================================
	// axi4-lite slave: one write and one read at a time
	logic        aw_hold_r, w_hold_r;
	logic [7:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        wr_go, wr_hit, rd_hit;
	logic [31:0] rd_val;
	assign wr_go = aw_hold_r & w_hold_r & ~BVALID;

	// address and data are taken in either order, answer follows both
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			awaddr_r  <= 8'h00;
			wdata_r   <= 32'h0;
			wstrb_r   <= 4'h0;
			AWREADY   <= 1'b0;
			WREADY    <= 1'b0;
			BVALID    <= 1'b0;
			BRESP     <= `PCP_RESP_OK;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_hold_r <= 1'b1;
				awaddr_r  <= AWADDR;
			end else if (wr_go) begin
				aw_hold_r <= 1'b0;
			end
			if (WVALID && WREADY) begin
				w_hold_r <= 1'b1;
				wdata_r  <= WDATA;
				wstrb_r  <= WSTRB;
			end else if (wr_go) begin
				w_hold_r <= 1'b0;
			end
			AWREADY <= ~aw_hold_r & ~(AWVALID & AWREADY) & ~BVALID;
			WREADY  <= ~w_hold_r & ~(WVALID & WREADY) & ~BVALID;
			if (wr_go) begin
				BVALID <= 1'b1;
				BRESP  <= wr_hit ? `PCP_RESP_OK : `PCP_RESP_ERR;
			end else if (BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	// read answer is registered one cycle after the address is taken
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b0;
			RDATA   <= 32'h0;
			RRESP   <= `PCP_RESP_OK;
		end else begin
			ARREADY <= ~RVALID & ~(ARVALID & ARREADY);
			if (ARVALID && ARREADY) begin
				RVALID <= 1'b1;
				RDATA  <= rd_hit ? rd_val : 32'h0;
				RRESP  <= rd_hit ? `PCP_RESP_OK : `PCP_RESP_ERR;
			end else if (RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end

	// byte-lane merge of a write into a register
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		end
		return r;
	endfunction

	// ==================================================================
	// global registers
	logic [31:0] ctrl_r, nco_r, frame_r, idle_r, wr_val_nco;
	logic [PCP_NCH-1:0] rx_rdy_r, rx_done;
	logic [31:0] ch_pos_r [PCP_NCH], ch_len_r [PCP_NCH], ch_fmt_r [PCP_NCH];
	logic [31:0] ch_txd_r [PCP_NCH], ch_rxd_r [PCP_NCH];
	logic [PCP_NCH-1:0] ch_hit;
	assign wr_val_nco = merge(nco_r, wdata_r, wstrb_r);

	// global config writes; phase increment is clamped to the legal clock range
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			ctrl_r  <= `PCP_CTRL_RST;
			nco_r   <= `PCP_NCO_RST;
			frame_r <= `PCP_FRAME_RST;
			idle_r  <= `PCP_IDLE_RST;
		end else if (wr_go) begin
			if (awaddr_r == `PCP_A_CTRL)
				ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
			if (awaddr_r == `PCP_A_NCO) begin
				if (64'(wr_val_nco) < PCP_INC_MIN)
					nco_r <= 32'(PCP_INC_MIN);
				else if (64'(wr_val_nco) > PCP_INC_MAX)
					nco_r <= 32'(PCP_INC_MAX);
				else
					nco_r <= wr_val_nco;
			end
			if (awaddr_r == `PCP_A_FRAME)
				frame_r <= merge(frame_r, wdata_r, wstrb_r);
			if (awaddr_r == `PCP_A_IDLE)
				idle_r <= merge(idle_r, wdata_r, wstrb_r);
		end
	end

	// receive-ready flags: write one to clear, a new word wins over the clear
	always_ff @(posedge REF_CLK) begin
		if (!RESETN)
			rx_rdy_r <= '0;
		else
			rx_rdy_r <= rx_done | (rx_rdy_r &
				~((wr_go && awaddr_r == `PCP_A_STAT) ? wdata_r[PCP_NCH-1:0] : '0));
	end

	// ==================================================================
	// pin synchronisers: three stages, a change counts once stages two and three agree
	logic [2:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r;
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			pin_s1_r <= 3'b000;
			pin_s2_r <= 3'b000;
			pin_s3_r <= 3'b000;
			pin_f_r  <= 3'b000;
		end else begin
			pin_s1_r <= {DIN, FSYNC_IN, BCLK_IN};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			for (int i = 0; i < 3; i++) begin
				if (pin_s2_r[i] == pin_s3_r[i])
					pin_f_r[i] <= pin_s3_r[i];
			end
		end
	end

	// ==================================================================
	// master clock generator: phase accumulator gives any rate from 64 kHz to 4.096 MHz, at the cost of one ref period of jitter
	logic       en, master, edge_f, long_fs, i2s;
	logic [31:0] acc_r, acc_nxt;
	pcp_pos_t   mcnt_r, frame_len, fs_len, slot;
	logic       m_rise, m_fall, in_idle, m_drv, idle_nxt;
	pcp_pos_t   mcnt_nxt;
	assign en        = ctrl_r[`PCP_C_EN];
	assign master    = ctrl_r[`PCP_C_MASTER];
	assign edge_f    = ctrl_r[`PCP_C_EDGE];
	assign long_fs   = ctrl_r[`PCP_C_LONG];
	assign i2s       = ctrl_r[`PCP_C_I2S];
	assign slot      = (frame_r[`PCP_F_LO] >> 1) > `PCP_SLOT_MAX ? `PCP_SLOT_MAX : (frame_r[`PCP_F_LO] >> 1);
	assign frame_len = i2s ? pcp_pos_t'(slot << 1) : frame_r[`PCP_F_LO];
	assign fs_len    = i2s ? slot : frame_r[`PCP_F_HI];
	assign acc_nxt   = (en && master) ? acc_r + nco_r : 32'h0;
	assign m_rise    = acc_nxt[31] & ~acc_r[31];
	assign m_fall    = ~acc_nxt[31] & acc_r[31];
	assign m_drv     = edge_f ? m_fall : m_rise;
	assign in_idle   = ctrl_r[`PCP_C_IDLE] && mcnt_r >= idle_r[`PCP_F_LO] && mcnt_r < idle_r[`PCP_F_HI];
	assign mcnt_nxt  = !m_rise ? mcnt_r : ((mcnt_r >= frame_len - 10'd1) ? '0 : mcnt_r + 10'd1);
	// gap judged on the count this edge carries, so no runt pulse at either end of the gap
	assign idle_nxt  = ctrl_r[`PCP_C_IDLE] && mcnt_nxt >= idle_r[`PCP_F_LO] && mcnt_nxt < idle_r[`PCP_F_HI];

	// period counter runs through the idle gap, so the gap is timed in clock periods
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			acc_r     <= 32'h0;
			mcnt_r    <= '0;
			BCLK_OUT  <= 1'b0;
			FSYNC_OUT <= 1'b0;
		end else begin
			acc_r <= acc_nxt;
			mcnt_r <= mcnt_nxt;
			BCLK_OUT <= acc_nxt[31] & ~idle_nxt;
			if (!(en && master))
				FSYNC_OUT <= ctrl_r[`PCP_C_FSINV];
			else if (m_drv)
				FSYNC_OUT <= ctrl_r[`PCP_C_FSINV] ^ (long_fs ? (mcnt_r < fs_len) : (mcnt_r == '0));
		end
	end

	// pin directions follow the role
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			BCLK_OE  <= 1'b0;
			FSYNC_OE <= 1'b0;
		end else begin
			BCLK_OE  <= master;
			FSYNC_OE <= master;
		end
	end

	// ==================================================================
	// frame bit counter, restarted by each rising strobe edge seen on the sampling edge
	logic     bclk_lvl, bclk_prev_r, rise, fall, smp_e, drv_e, fs_lvl, fs_prev_r, din_lvl, fstart;
	pcp_pos_t pos_r, pos_nxt;
	assign bclk_lvl = master ? BCLK_OUT : pin_f_r[0];
	assign rise     = bclk_lvl & ~bclk_prev_r;
	assign fall     = ~bclk_lvl & bclk_prev_r;
	assign smp_e    = edge_f ? rise : fall;
	assign drv_e    = edge_f ? fall : rise;
	assign fs_lvl   = (master ? FSYNC_OUT : pin_f_r[1]) ^ ctrl_r[`PCP_C_FSINV];
	assign din_lvl  = pin_f_r[2] ^ ctrl_r[`PCP_C_DININV];
	assign fstart   = smp_e & fs_lvl & ~fs_prev_r;
	assign pos_nxt  = fstart ? '0 : ((pos_r == '1) ? pos_r : pos_r + 10'd1);

	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			bclk_prev_r <= 1'b0;
			fs_prev_r   <= 1'b0;
			pos_r       <= '1;
		end else begin
			bclk_prev_r <= bclk_lvl;
			if (smp_e) begin
				fs_prev_r <= fs_lvl;
				pos_r     <= pos_nxt;
			end
		end
	end

	// ==================================================================
	// per-channel shifting
	logic [PCP_NCH-1:0] tx_act, tx_bit;
	logic [9:0] len_max;
	assign len_max = (ch_fmt_r[0][`PCP_M_CHEN] && ch_fmt_r[1][`PCP_M_CHEN]) ? `PCP_LEN_MAX2 : `PCP_LEN_MAX1;

	for (genvar c = 0; c < PCP_NCH; c++) begin : g_ch
		localparam logic [7:0] BASE = 8'(`PCP_A_CH_BASE + c * `PCP_A_CH_STEP);
		logic [9:0]  tl, rl, ts, rs, tk, rk;
		logic        tlsb, rlsb, rx_in;
		logic [31:0] txw_r, rsh_r, rsh_v, tx_src;
		logic [DATA_W-1:0] dummy;
		pcp_coding_e code;
		assign code = pcp_coding_e'(ch_fmt_r[c][`PCP_F_CODE]);
		assign ch_hit[c] = awaddr_r[7:4] == BASE[7:4];

		// effective lengths: clamped to range, short bursts on a fast slave clock
		function automatic logic [9:0] eff_len(input logic [9:0] raw);
			logic [9:0] l;
			l = raw < `PCP_LEN_MIN ? `PCP_LEN_MIN : (raw > len_max ? len_max : raw);
			if (ctrl_r[`PCP_C_HS] && !master && l > `PCP_BURST_HS)
				l = `PCP_BURST_HS;
			if (i2s && l > slot)
				l = slot;
			return l;
		endfunction
		// process form, so a change of mode or role re-evaluates the clamp too
		always_comb begin
			tl = eff_len(ch_len_r[c][`PCP_F_LO]);
			rl = eff_len(ch_len_r[c][`PCP_F_HI]);
		end
		assign ts = i2s ? pcp_pos_t'(c * slot) : ch_pos_r[c][`PCP_F_LO];
		assign rs = i2s ? pcp_pos_t'(c * slot) : ch_pos_r[c][`PCP_F_HI];
		assign tlsb = ch_fmt_r[c][`PCP_M_TXLSB] && tl <= `PCP_LSB_MAX;
		assign rlsb = ch_fmt_r[c][`PCP_M_RXLSB] && rl <= `PCP_LSB_MAX;
		assign tk = pos_r - ts;
		assign rk = pos_nxt - rs;
		assign rx_in = ch_fmt_r[c][`PCP_M_CHEN] && en && pos_nxt >= rs && rk < rl;
		assign tx_act[c] = ch_fmt_r[c][`PCP_M_CHEN] && en && pos_r >= ts && tk < tl;
		assign dummy = DATA_W'(txw_r);
		assign tx_bit[c] = tlsb ? (tk < 10'd32 && txw_r[tk[4:0]]) :
			(((tl - 10'd1 - tk) < 10'd32) && txw_r[5'(tl - 10'd1 - tk)]);
		assign tx_src = (code == PCP_ULAW) ? {24'h0, enc_mu(ch_txd_r[c][15:0])} :
			(code == PCP_ALAW) ? {24'h0, enc_a(ch_txd_r[c][15:0])} : ch_txd_r[c];

		// received word with the current bit placed in its order
		always_comb begin
			rsh_v = (rk == 10'd0) ? 32'h0 : rsh_r;
			if (rlsb) begin
				if (rk < 10'd32)
					rsh_v[rk[4:0]] = din_lvl;
			end else begin
				rsh_v = {rsh_v[30:0], din_lvl};
			end
		end

		// config writes for this channel
		always_ff @(posedge REF_CLK) begin
			if (!RESETN) begin
				ch_pos_r[c] <= `PCP_POS_RST;
				ch_len_r[c] <= `PCP_LEN_RST;
				ch_fmt_r[c] <= `PCP_FMT_RST;
				ch_txd_r[c] <= 32'h0;
			end else if (wr_go && ch_hit[c]) begin
				if ({4'h0, awaddr_r[3:0]} == `PCP_A_POS)
					ch_pos_r[c] <= merge(ch_pos_r[c], wdata_r, wstrb_r);
				if ({4'h0, awaddr_r[3:0]} == `PCP_A_LEN)
					ch_len_r[c] <= merge(ch_len_r[c], wdata_r, wstrb_r);
				if ({4'h0, awaddr_r[3:0]} == `PCP_A_FMT)
					ch_fmt_r[c] <= merge(ch_fmt_r[c], wdata_r, wstrb_r);
				if ({4'h0, awaddr_r[3:0]} == `PCP_A_DATA)
					ch_txd_r[c] <= merge(ch_txd_r[c], wdata_r, wstrb_r);
			end
		end

		// transmit word snapshot at frame start; receive shift on sampling edges
		always_ff @(posedge REF_CLK) begin
			if (!RESETN) begin
				txw_r       <= 32'h0;
				rsh_r       <= 32'h0;
				ch_rxd_r[c] <= 32'h0;
				rx_done[c]  <= 1'b0;
			end else begin
				rx_done[c] <= 1'b0;
				if (fstart)
					txw_r <= tx_src;
				if (smp_e && rx_in) begin
					rsh_r <= rsh_v;
					if (rk == rl - 10'd1) begin
						rx_done[c] <= 1'b1;
						if (code == PCP_ULAW)
							ch_rxd_r[c] <= 32'(signed'(dec_mu(rsh_v[7:0])));
						else if (code == PCP_ALAW)
							ch_rxd_r[c] <= 32'(signed'(dec_a(rsh_v[7:0])));
						else
							ch_rxd_r[c] <= rsh_v;
					end
				end
			end
		end
	end

	// ==================================================================
	// serial output: floats between words and when held off; through the idle gap it keeps its state from the last drive edge
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			DOUT    <= 1'b0;
			DOUT_OE <= 1'b0;
		end else if (ctrl_r[`PCP_C_HIZ] || !en) begin
			DOUT    <= 1'b0;
			DOUT_OE <= 1'b0;
		end else if (drv_e) begin
			DOUT    <= |(tx_act & tx_bit);
			DOUT_OE <= |tx_act && !(master && in_idle);
		end
	end

	// ==================================================================
	// register read mux
	always_comb begin
		rd_hit = 1'b1;
		rd_val = 32'h0;
		if (32'(ARADDR[7:4]) >= 32'(`PCP_A_CH_BASE >> 4) && 32'(ARADDR[7:4]) < 32'(`PCP_A_CH_BASE >> 4) + PCP_NCH) begin
			unique case ({4'h0, ARADDR[3:0]})
				`PCP_A_POS:  rd_val = ch_pos_r[ARADDR[4]];
				`PCP_A_LEN:  rd_val = ch_len_r[ARADDR[4]];
				`PCP_A_FMT:  rd_val = ch_fmt_r[ARADDR[4]];
				`PCP_A_DATA: rd_val = ch_rxd_r[ARADDR[4]];
				default:     rd_hit = 1'b0;
			endcase
		end else begin
			unique case (ARADDR)
				`PCP_A_CTRL:  rd_val = ctrl_r;
				`PCP_A_NCO:   rd_val = nco_r;
				`PCP_A_FRAME: rd_val = frame_r;
				`PCP_A_IDLE:  rd_val = idle_r;
				`PCP_A_STAT: begin
					rd_val = 32'h0;
					rd_val[PCP_NCH-1:0] = rx_rdy_r;
					rd_val[`PCP_S_IDLE] = in_idle;
					rd_val[`PCP_F_HI]   = pos_r;
				end
				default:      rd_hit = 1'b0;
			endcase
		end
	end

	// write decode: anything outside the map answers with an error
	assign wr_hit = (awaddr_r == `PCP_A_CTRL) || (awaddr_r == `PCP_A_NCO) || (awaddr_r == `PCP_A_FRAME) ||
		(awaddr_r == `PCP_A_IDLE) || (awaddr_r == `PCP_A_STAT) || ((|ch_hit) && awaddr_r[1:0] == 2'b00);
endmodule

// ===== common/pcp_defs.svh
// register map, field positions, reset values and timing figures of the codec port
`ifndef PCP_DEFS_SVH
`define PCP_DEFS_SVH

// ==================================================================
// register byte offsets
`define PCP_A_CTRL      8'h00
`define PCP_A_NCO       8'h04
`define PCP_A_FRAME     8'h08
`define PCP_A_IDLE      8'h0c
`define PCP_A_STAT      8'h10
`define PCP_A_CH_BASE   8'h20
`define PCP_A_CH_STEP   8'h10
`define PCP_A_POS       8'h00
`define PCP_A_LEN       8'h04
`define PCP_A_FMT       8'h08
`define PCP_A_DATA      8'h0c

// ==================================================================
// control bits
`define PCP_C_EN        0
`define PCP_C_MASTER    1
`define PCP_C_EDGE      2
`define PCP_C_FSINV     3
`define PCP_C_DININV    4
`define PCP_C_HIZ       5
`define PCP_C_LONG      6
`define PCP_C_IDLE      7
`define PCP_C_I2S       8
`define PCP_C_HS        9

// ==================================================================
// shared field positions, format bits and status bits
`define PCP_F_LO        9:0
`define PCP_F_HI        25:16
`define PCP_F_CODE      1:0
`define PCP_M_TXLSB     2
`define PCP_M_RXLSB     3
`define PCP_M_CHEN      4
`define PCP_S_IDLE      2

// ==================================================================
// reset values
`define PCP_CTRL_RST    32'h0000_0020
`define PCP_NCO_RST     32'h068d_b8bb
`define PCP_FRAME_RST   32'h0001_0040
`define PCP_IDLE_RST    32'h0000_0000
`define PCP_POS_RST     32'h0000_0000
`define PCP_LEN_RST     32'h0010_0010
`define PCP_FMT_RST     32'h0000_0000

// ==================================================================
// length limits in bit clocks
`define PCP_LEN_MIN     10'd8
`define PCP_LEN_MAX2    10'd320
`define PCP_LEN_MAX1    10'd640
`define PCP_SLOT_MAX    10'd40
`define PCP_BURST_HS    10'd32
`define PCP_LSB_MAX     10'd24

// ==================================================================
// clock figures in hertz
`define PCP_REF_HZ      40_000_000
`define PCP_BCLK_MIN_HZ 64_000
`define PCP_BCLK_MAX_HZ 4_096_000
`define PCP_SLV_MAX_HZ  15_000_000
`define PCP_SLV_HS_HZ   12_000_000

// ==================================================================
// companding constants and bus answers
`define PCP_MU_BIAS     17'h00084
`define PCP_MU_CLIP     17'h07f7b
`define PCP_A_XOR       8'h55
`define PCP_RESP_OK     2'b00
`define PCP_RESP_ERR    2'b10

`endif

// ===== common/pcp_pkg.sv
// types and derived constants of the codec port
`include "pcp_defs.svh"
package pcp_pkg;
	// ==================================================================
	// sample encodings
	typedef enum logic [1:0] {
		PCP_LIN  = 2'h0,
		PCP_ALAW = 2'h1,
		PCP_ULAW = 2'h2
	} pcp_coding_e;

	typedef logic [9:0] pcp_pos_t;

	localparam int unsigned PCP_NCH = 2;

	// ==================================================================
	// phase increment limits for the bit clock generator
	localparam longint unsigned PCP_ACC_SPAN = 64'h1_0000_0000;
	localparam longint unsigned PCP_INC_MIN  = (`PCP_BCLK_MIN_HZ * PCP_ACC_SPAN + `PCP_REF_HZ - 1) / `PCP_REF_HZ;
	localparam longint unsigned PCP_INC_MAX  = (`PCP_BCLK_MAX_HZ * PCP_ACC_SPAN) / `PCP_REF_HZ;
endpackage

// ===== tb/pcp_codec_port_assertions.sv
// port-level checker of the codec port, bound to the top module
`timescale 1ns/100ps
module pcp_chk (
	input wire logic        REF_CLK,
	input wire logic        RESETN,
	input wire logic        AWVALID,
	input wire logic        AWREADY,
	input wire logic        WVALID,
	input wire logic        WREADY,
	input wire logic        BVALID,
	input wire logic        BREADY,
	input wire logic [1:0]  BRESP,
	input wire logic        ARVALID,
	input wire logic        ARREADY,
	input wire logic        RVALID,
	input wire logic        RREADY,
	input wire logic [1:0]  RRESP,
	input wire logic [31:0] RDATA,
	input wire logic        BCLK_OUT,
	input wire logic        BCLK_OE,
	input wire logic        FSYNC_OE,
	input wire logic        DOUT_OE
);
	// ==================================================================
	// one domain, so clock and reset are given once
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RESETN);

	a_b_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write answer dropped early");
	a_r_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
		else $error("read answer dropped early");
	a_w_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:3] BVALID)
		else $error("write answer late");
	a_r_answer: assert property (ARVALID && ARREADY |-> ##[1:2] RVALID)
		else $error("read answer late");
	a_aw_block: assert property (BVALID |-> !AWREADY)
		else $error("address taken while answer pending");
	a_oe_pair: assert property (BCLK_OE == FSYNC_OE)
		else $error("clock and strobe directions differ");
	a_slave_clk: assert property (!BCLK_OE |-> !BCLK_OUT)
		else $error("bit clock driven as slave");
	a_reset_hiz: assert property ($rose(RESETN) |-> !DOUT_OE ##1 !DOUT_OE)
		else $error("data line driven after reset");
	// a phase shorter than four cycles means a clock above the top rate
	a_bclk_high: assert property ($rose(BCLK_OUT) |-> (BCLK_OUT || !BCLK_OE) [*4])
		else $error("bit clock high phase too short");
	a_bclk_low: assert property ($fell(BCLK_OUT) && BCLK_OE |-> !BCLK_OUT [*4])
		else $error("bit clock low phase too short");

	c_dout: cover property ($rose(DOUT_OE));
	c_bclk: cover property ($rose(BCLK_OUT));
	c_rerr: cover property (RVALID && RRESP == 2'b10);
endmodule

bind pcp_codec_port pcp_chk chk_u (.*);

// ===== tb/pcp_codec_model.sv
// behavioural codec that masters the bit clock and frame strobe
`timescale 1ns/100ps
module pcp_codec_model (
	output logic      bclk,
	output logic      fsync,
	output logic      din,
	input  wire logic dout
);
	// clock stands low outside frames
	initial begin
		bclk = 0;
		fsync = 0;
		din = 0;
	end

	// one short-strobe frame; 16-bit bursts stay under the burst cap
	task frame(input logic [15:0] w, output logic [15:0] r);
		#7;
		for (int k = 0; k < 20; k++) begin
			fsync = (k == 0);
			din = (k < 16) ? w[15 - k] : ~din;
			if (k >= 2 && k < 18) r = {r[14:0], dout};
			bclk = 1; // 200 ns period, far below the slave limit
			#100 bclk = 0;
			#100;
		end
		din = ~din; // released line does not keep its last value
	endtask
endmodule

// ===== tb/pcp_codec_port_bench.sv
// self-checking bench of the codec port
`timescale 1ns/100ps
`include "pcp_defs.svh"
module pcp_codec_port_bench;
	logic        REF_CLK = 0;
	logic        RESETN  = 0;
	logic [7:0]  AWADDR  = 0;
	logic [7:0]  ARADDR  = 0;
	logic [31:0] WDATA   = 0;
	logic        AWVALID = 0;
	logic        WVALID  = 0;
	logic        BREADY  = 0;
	logic        ARVALID = 0;
	logic        RREADY  = 0;
	logic [31:0] RDATA, d, tx, rx;
	logic [31:0] seed = 32'd98154;
	logic [1:0]  BRESP, RRESP, r;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, BCLK_OUT, BCLK_OE;
	logic        FSYNC_OUT, FSYNC_OE, DOUT, DOUT_OE, m_bclk, m_fs, m_din, oe_seen, p, q;
	logic [15:0] got;
	int          n_fail = 0;
	int          compares = 0;
	int          i, n, m;
	// pins resolved from whichever side drives them
	wire         bclk_w = BCLK_OE ? BCLK_OUT : m_bclk;
	wire         fs_w   = FSYNC_OE ? FSYNC_OUT : m_fs;
	wire         dout_w = DOUT_OE ? DOUT : 1'bz;

	pcp_codec_port dut_u (.*, .AWPROT(3'h0), .WSTRB(4'hf), .ARPROT(3'h0),
		.BCLK_IN(bclk_w), .FSYNC_IN(fs_w), .DIN(m_din));
	pcp_codec_model codec_u (.bclk(m_bclk), .fsync(m_fs), .din(m_din), .dout(dout_w));

	// ==================================================================
	// clock, line monitor, helpers
	initial forever #12.5 REF_CLK = ~REF_CLK;
	always @(posedge REF_CLK) if (DOUT_OE === 1'b1) oe_seen <= 1'b1;

	function logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function logic [15:0] rev(input logic [15:0] w);
		for (int k = 0; k < 16; k++) rev[k] = w[15 - k];
	endfunction
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// bus master: hold each channel until its ready, answer until valid
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge REF_CLK);
		AWADDR <= a;
		WDATA <= v;
		AWVALID <= 1;
		WVALID <= 1;
		BREADY <= 1;
		do begin
			@(posedge REF_CLK);
			if (AWREADY) AWVALID <= 0;
			if (WREADY) WVALID <= 0;
		end while (!BVALID);
		BREADY <= 0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
		@(posedge REF_CLK);
		ARADDR <= a;
		ARVALID <= 1;
		RREADY <= 1;
		do begin
			@(posedge REF_CLK);
			if (ARREADY) ARVALID <= 0;
		end while (!RVALID);
		v = RDATA;
		s = RRESP;
		RREADY <= 0;
	endtask
	task close_out;
		$display("mismatches %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// ==================================================================
	// scenarios: reset state, unmapped access, four bit orders, hi-z frame, falling-edge frame, master clock
	initial begin
		repeat (4) @(posedge REF_CLK);
		RESETN <= 1;
		@(posedge REF_CLK);
		#1 chk(DOUT_OE, 0);
		rd(`PCP_A_CTRL, d, r);
		chk(d, `PCP_CTRL_RST);
		rd(8'hfc, d, r);
		chk(r, `PCP_RESP_ERR);
		chk(d, 32'h0);
		wr(8'hfc, 32'h0);
		chk(BRESP, `PCP_RESP_ERR);
		for (i = 0; i < 6; i++) begin
			seed = xs(seed);
			tx = seed;
			seed = xs(seed);
			rx = seed;
			wr(`PCP_A_CH_BASE + `PCP_A_FMT, 32'h10 | (i << 2));
			wr(`PCP_A_CH_BASE + `PCP_A_DATA, tx);
			wr(`PCP_A_CTRL, (i == 4) ? 32'h21 : ((i == 5) ? 32'h5 : 32'h1));
			oe_seen = 0;
			codec_u.frame(rx[15:0], got);
			if (i != 4) chk(got, i[0] ? rev(tx[15:0]) : tx[15:0]);
			rd(`PCP_A_CH_BASE + `PCP_A_DATA, d, r);
			chk(d[15:0], i[1] ? rev(rx[15:0]) : rx[15:0]);
			chk(oe_seen, i != 4);
			chk(DOUT_OE, 0);
		end
		wr(`PCP_A_CTRL, 32'h3);
		n = 0;
		m = 0;
		p = 0;
		q = 0;
		repeat (400) begin
			@(posedge REF_CLK);
			if (BCLK_OUT && !p) n++;
			if (FSYNC_OUT && !q) m++;
			p = BCLK_OUT;
			q = FSYNC_OUT;
		end
		chk(BCLK_OE, 1);
		chk(n >= 10 && n <= 11, 1);
		chk(m, 1);
		wr(`PCP_A_CTRL, 32'h0);
		// direction follows the control word one cycle after the write lands
		#1 chk(BCLK_OE, 0);
		chk(FSYNC_OUT, 0);
		close_out;
	end
	// watchdog well beyond the expected run
	initial begin
		#400000;
		n_fail++;
		close_out;
	end
endmodule
